/* verilog/smaf_filter.sv */
// Function
// - With match enable in 9-bit mode, only ninth-bit-one frames are address candidates.
// - With match enable in 9-bit mode, receive done rises only on given or broadcast match.
// - With match enable clear, ninth-bit-zero data frames are accepted and flagged.
// - Given match: byte equals station address wherever mask holds one.
// - Broadcast: byte has a one wherever address OR mask is one.
// - Station address sits at A9H, its mask at B9H.
// - Reset clears address and mask so every address byte matches.
// - Modes 1 to 3 check the stop bit and set framing error when missing.
// - Framing error stays set through good frames until software clears it.
// - Control bit 7 is mode-high or framing error, chosen by flag-view select.
// - Power control at 87H: doubler, view select, unused, power-off, flags, down, wait.
// - Serial control at 98H holds mode, match enable, rx enable, ninth bits, done flags.
// - Mode 2 runs a fixed rate, mode 3 a variable rate; both carry nine bits.
// - Receive done never clears itself; software clears it.
// - While waiting in low power, only an accepted frame wakes the station; with the filter on, a matching address.
// - Nine-bit frame: start zero, eight data LSB first, ninth bit, stop one.
// - No frame is accepted unless receive enable is set.
// - Mode 2 bit rate is clock/64, or clock/32 with the doubler set.
// Purpose: Serial port receive filter with transmitter, on the special-function bus
// Assumes: Inputs synchronous to clk; baud_tick pulses at 16x the variable bit rate
// Notes: Mode 0 is not served; a two-entry buffer sits between receiver and buffer register
`timescale 1ns/1ps
module smaf_filter import smaf_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic rxd,
  input wire logic baud_tick,
  output logic txd,
  output logic rx_done,
  output logic tx_done,
  output logic low_power_wait,
  output logic power_down
);
  function automatic logic given_match(input logic [7:0] b, input logic [7:0] a, input logic [7:0] m);
    given_match = ((b ^ a) & m) == 8'h00;
  endfunction
  function automatic logic bcast_match(input logic [7:0] b, input logic [7:0] a, input logic [7:0] m);
    bcast_match = ((a | m) & ~b) == 8'h00;
  endfunction

  logic mode_hi_ff, mode_lo_ff, match_en_ff, ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff, fe_ff;
  logic dbl_ff, view_ff, pof_ff, gf1_ff, gf0_ff, pd_ff, idl_ff;
  logic [7:0] station_address_ff, station_address_mask_ff, serial_buffer_ff;
  logic [4:0] div_ff;
  smaf_rx_e rx_st_ff;
  logic [3:0] rx_cnt_ff, rx_bit_ff;
  logic [8:0] rx_sh_ff;
  logic stop_ff, rxd_q_ff;
  logic [8:0] fifo_mem [0:1];
  logic wr_ptr_ff, rd_ptr_ff;
  logic [1:0] fifo_cnt_ff;
  logic tx_busy_ff;
  logic [3:0] tx_cnt_ff, tx_bit_ff, tx_len_ff;
  logic [10:0] tx_sh_ff;
  logic [7:0] rd_mux;

  wire wr_serial_control = ce && sfr_wr && (sfr_addr == SMAF_SERIAL_CONTROL_ADDR);
  wire wr_power_control = ce && sfr_wr && (sfr_addr == SMAF_POWER_CONTROL_ADDR);
  wire wr_serial_buffer = ce && sfr_wr && (sfr_addr == SMAF_SERIAL_BUFFER_ADDR);
  wire wr_station_address = ce && sfr_wr && (sfr_addr == SMAF_STATION_ADDRESS_ADDR);
  wire wr_station_address_mask = ce && sfr_wr && (sfr_addr == SMAF_STATION_ADDRESS_MASK_ADDR);
  wire [1:0] mode = {mode_hi_ff, mode_lo_ff};
  wire mode9 = mode_hi_ff;
  wire rx_mode_on = mode_hi_ff || mode_lo_ff;
  // A start needs a high-to-low step, so a stop bit held low cannot restart the receiver
  wire rx_fall = rxd_q_ff && !rxd;
  // Fixed-rate mode counts the oscillator; the variable modes borrow the external timer tick
  wire [4:0] div_last = dbl_ff ? SMAF_TICK_FAST : SMAF_TICK_SLOW;
  wire s_tick = ce && ((mode == SMAF_MODE_FIXED) ? (div_ff == div_last) : baud_tick);
  wire sample_end = s_tick && (rx_cnt_ff == SMAF_SAMPLE_LAST);
  wire [3:0] rx_nbits = mode9 ? SMAF_BITS_NINE : SMAF_BITS_EIGHT;
  wire [7:0] rx_byte = mode9 ? rx_sh_ff[7:0] : rx_sh_ff[8:1];
  wire rx_ninth = mode9 ? rx_sh_ff[8] : stop_ff;
  wire addr_hit = given_match(rx_byte, station_address_ff, station_address_mask_ff) || bcast_match(rx_byte, station_address_ff, station_address_mask_ff);
  wire filter_on = mode9 && match_en_ff;
  wire rx_accept = ren_ff && (!filter_on || (rx_ninth && addr_hit));
  wire in_ready = fifo_cnt_ff != SMAF_FIFO_DEPTH;
  wire in_push = ce && (rx_st_ff == RX_PUSH) && rx_accept && in_ready;
  wire fe_set = ce && (rx_st_ff == RX_PUSH) && !stop_ff;
  // Drain side stalls while receive done is still pending in software
  wire out_valid = fifo_cnt_ff != 2'h0;
  wire out_pop = ce && out_valid && !ri_ff;
  wire tx_start = wr_serial_buffer && !tx_busy_ff;
  wire tx_bit_end = tx_busy_ff && s_tick && (tx_cnt_ff == SMAF_SAMPLE_LAST);
  wire tx_last = tx_bit_end && (tx_bit_ff == tx_len_ff - 4'h1);

  always_comb begin
    if (sfr_addr == SMAF_SERIAL_CONTROL_ADDR) begin
      rd_mux = {view_ff ? fe_ff : mode_hi_ff, mode_lo_ff, match_en_ff, ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff};
    end else if (sfr_addr == SMAF_POWER_CONTROL_ADDR) begin
      rd_mux = {dbl_ff, view_ff, 1'b0, pof_ff, gf1_ff, gf0_ff, pd_ff, idl_ff};
    end else if (sfr_addr == SMAF_SERIAL_BUFFER_ADDR) begin
      rd_mux = serial_buffer_ff;
    end else if (sfr_addr == SMAF_STATION_ADDRESS_ADDR) begin
      rd_mux = station_address_ff;
    end else if (sfr_addr == SMAF_STATION_ADDRESS_MASK_ADDR) begin
      rd_mux = station_address_mask_ff;
    end else begin
      rd_mux = SMAF_UNMAPPED_READ;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sfr_rdata <= SMAF_REG_RESET;
    end else if (ce && sfr_rd) begin
      sfr_rdata <= rd_mux;
    end
  end

  // Serial control; hardware sets win over a same-cycle software clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {mode_hi_ff, mode_lo_ff, match_en_ff, ren_ff, tb8_ff, rb8_ff, ti_ff, ri_ff, fe_ff} <= 9'h000;
    end else if (ce) begin
      if (wr_serial_control) begin
        {mode_lo_ff, match_en_ff, ren_ff, tb8_ff} <= sfr_wdata[SC_MODE_LO:SC_TX9];
        if (!view_ff) begin
          mode_hi_ff <= sfr_wdata[SC_MODE_HI];
        end
      end
      fe_ff <= fe_set || ((wr_serial_control && view_ff) ? sfr_wdata[SC_MODE_HI] : fe_ff);
      ri_ff <= out_pop || (wr_serial_control ? sfr_wdata[SC_RI] : ri_ff);
      ti_ff <= tx_last || (wr_serial_control ? sfr_wdata[SC_TI] : ti_ff);
      if (out_pop) begin
        rb8_ff <= fifo_mem[rd_ptr_ff][8];
      end else if (wr_serial_control) begin
        rb8_ff <= sfr_wdata[SC_RX9];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {dbl_ff, view_ff, pof_ff, gf1_ff, gf0_ff, pd_ff, idl_ff} <= 7'h00;
      station_address_ff <= SMAF_REG_RESET;
      station_address_mask_ff <= SMAF_REG_RESET;
      serial_buffer_ff <= SMAF_REG_RESET;
    end else if (ce) begin
      if (wr_power_control) begin
        {dbl_ff, view_ff} <= sfr_wdata[PC_BAUD_DBL:PC_VIEW];
        {pof_ff, gf1_ff, gf0_ff, pd_ff} <= sfr_wdata[PC_POF:PC_PD];
      end
      // Only an accepted frame ends the low-power wait, so a mismatch never wakes us
      idl_ff <= !out_pop && (wr_power_control ? sfr_wdata[PC_IDL] : idl_ff);
      if (wr_station_address) begin
        station_address_ff <= sfr_wdata;
      end
      if (wr_station_address_mask) begin
        station_address_mask_ff <= sfr_wdata;
      end
      if (out_pop) begin
        serial_buffer_ff <= fifo_mem[rd_ptr_ff][7:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_ff <= 5'h00;
    end else if (ce) begin
      div_ff <= (div_ff >= div_last) ? 5'h00 : div_ff + 5'h01;
    end
  end

  // Receiver; a full buffer holds the frame in RX_PUSH until a slot frees
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_st_ff <= RX_IDLE;
      rx_cnt_ff <= 4'h0;
      rx_bit_ff <= 4'h0;
      rx_sh_ff <= 9'h000;
      stop_ff <= 1'b1;
      rxd_q_ff <= 1'b1;
    end else if (ce) begin
      rxd_q_ff <= rxd;
      case (rx_st_ff)
        RX_IDLE: begin
          rx_cnt_ff <= 4'h0;
          if (ren_ff && rx_mode_on && rx_fall) begin
            rx_st_ff <= RX_START;
          end
        end
        RX_START: begin
          if (s_tick) begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
            if (rx_cnt_ff == SMAF_SAMPLE_MID) begin
              rx_cnt_ff <= 4'h0;
              rx_bit_ff <= 4'h0;
              rx_st_ff <= rxd ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (s_tick) begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
          end
          if (sample_end) begin
            rx_sh_ff <= {rxd, rx_sh_ff[8:1]};
            rx_bit_ff <= rx_bit_ff + 4'h1;
            if (rx_bit_ff == rx_nbits - 4'h1) begin
              rx_st_ff <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (s_tick) begin
            rx_cnt_ff <= rx_cnt_ff + 4'h1;
          end
          if (sample_end) begin
            stop_ff <= rxd;
            rx_st_ff <= RX_PUSH;
          end
        end
        RX_PUSH: begin
          if (!rx_accept || in_ready) begin
            rx_st_ff <= RX_IDLE;
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // Two-entry buffer between the shifter and the buffer register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      fifo_cnt_ff <= 2'h0;
    end else if (ce) begin
      if (in_push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (out_pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      fifo_cnt_ff <= fifo_cnt_ff + {1'b0, in_push} - {1'b0, out_pop};
    end
  end

  always_ff @(posedge clk) begin
    if (in_push) begin
      fifo_mem[wr_ptr_ff] <= {rx_ninth, rx_byte};
    end
  end

  // Transmitter; a buffer write while busy is ignored rather than corrupting the frame
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_busy_ff <= 1'b0;
      tx_cnt_ff <= 4'h0;
      tx_bit_ff <= 4'h0;
      tx_len_ff <= SMAF_TX_LEN_NINE;
      tx_sh_ff <= 11'h7ff;
      txd <= 1'b1;
    end else if (ce) begin
      if (tx_start) begin
        tx_busy_ff <= 1'b1;
        tx_cnt_ff <= 4'h0;
        tx_bit_ff <= 4'h0;
        tx_len_ff <= mode9 ? SMAF_TX_LEN_NINE : SMAF_TX_LEN_EIGHT;
        tx_sh_ff <= {1'b1, mode9 ? tb8_ff : 1'b1, sfr_wdata, 1'b0};
        txd <= 1'b0;
      end else if (tx_busy_ff) begin
        if (s_tick) begin
          tx_cnt_ff <= tx_cnt_ff + 4'h1;
        end
        if (tx_bit_end) begin
          tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
          tx_bit_ff <= tx_bit_ff + 4'h1;
          txd <= tx_last ? 1'b1 : tx_sh_ff[1];
          tx_busy_ff <= !tx_last;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_done <= 1'b0;
      tx_done <= 1'b0;
      low_power_wait <= 1'b0;
      power_down <= 1'b0;
    end else begin
      rx_done <= ri_ff;
      tx_done <= ti_ff;
      low_power_wait <= idl_ff;
      power_down <= pd_ff;
    end
  end

  sequence tx_kick_s;
    tx_start;
  endsequence
  sequence tx_line_low_s;
    tx_busy_ff && !txd;
  endsequence

  addr_candidate_a: assert property (@(posedge clk) disable iff (reset)
    in_push && filter_on |-> rx_ninth) else $error("address frame accepted with ninth bit zero");
  addr_match_a: assert property (@(posedge clk) disable iff (reset)
    in_push && filter_on |-> (given_match(rx_byte, station_address_ff, station_address_mask_ff) || bcast_match(rx_byte, station_address_ff, station_address_mask_ff)))
    else $error("unmatched address accepted");
  data_accept_a: assert property (@(posedge clk) disable iff (reset)
    ce && rx_st_ff == RX_PUSH && ren_ff && !match_en_ff && in_ready |=> fifo_cnt_ff != 2'h0)
    else $error("data frame dropped with filter off");
  fe_set_a: assert property (@(posedge clk) disable iff (reset)
    ce && rx_st_ff == RX_PUSH && !stop_ff |=> fe_ff) else $error("missing stop bit not flagged");
  fe_sticky_a: assert property (@(posedge clk) disable iff (reset)
    fe_ff && !(wr_serial_control && view_ff) |=> fe_ff) else $error("framing error cleared by hardware");
  ri_hold_a: assert property (@(posedge clk) disable iff (reset)
    ri_ff && !wr_serial_control |=> ri_ff [*2] or (ri_ff ##1 $past(wr_serial_control))) else $error("receive done cleared itself");
  rx_off_a: assert property (@(posedge clk) disable iff (reset)
    !ren_ff |-> !in_push) else $error("frame accepted with receiver disabled");
  tx_begin_a: assert property (@(posedge clk) disable iff (reset)
    tx_kick_s |=> tx_line_low_s) else $error("buffer write did not start a frame");
  rx_done_out_a: assert property (@(posedge clk) disable iff (reset)
    $rose(ri_ff) && !$past(wr_serial_control) |-> $past(out_valid) ##1 rx_done) else $error("receive done raised without data");
endmodule // smaf_filter

/* verilog/smaf_pkg.sv */
// Purpose: Constants and types for the multidrop serial address filter
// Assumes: clk is the controller oscillator, 100 MHz
// Notes: Register addresses are special-function addresses on the controller bus
package smaf_pkg;
  localparam logic [7:0] SMAF_POWER_CONTROL_ADDR = 8'h87;
  localparam logic [7:0] SMAF_SERIAL_CONTROL_ADDR = 8'h98;
  localparam logic [7:0] SMAF_SERIAL_BUFFER_ADDR = 8'h99;
  localparam logic [7:0] SMAF_STATION_ADDRESS_ADDR = 8'ha9;
  localparam logic [7:0] SMAF_STATION_ADDRESS_MASK_ADDR = 8'hb9;
  localparam logic [7:0] SMAF_REG_RESET = 8'h00;
  localparam logic [7:0] SMAF_UNMAPPED_READ = 8'h00;
  // serial_control field positions
  localparam int SC_MODE_HI = 7;
  localparam int SC_MODE_LO = 6;
  localparam int SC_MATCH_EN = 5;
  localparam int SC_RX_EN = 4;
  localparam int SC_TX9 = 3;
  localparam int SC_RX9 = 2;
  localparam int SC_TI = 1;
  localparam int SC_RI = 0;
  // power_control field positions
  localparam int PC_BAUD_DBL = 7;
  localparam int PC_VIEW = 6;
  localparam int PC_POF = 4;
  localparam int PC_GF1 = 3;
  localparam int PC_GF0 = 2;
  localparam int PC_PD = 1;
  localparam int PC_IDL = 0;
  // Bit timing: 16 samples per bit; fixed-rate mode divides the oscillator by 64 or 32
  localparam int SMAF_SAMPLES = 16;
  localparam int SMAF_FIXED_DIV_SLOW = 64;
  localparam int SMAF_FIXED_DIV_FAST = 32;
  localparam logic [4:0] SMAF_TICK_SLOW = 5'(SMAF_FIXED_DIV_SLOW / SMAF_SAMPLES - 1);
  localparam logic [4:0] SMAF_TICK_FAST = 5'(SMAF_FIXED_DIV_FAST / SMAF_SAMPLES - 1);
  localparam logic [3:0] SMAF_SAMPLE_LAST = 4'(SMAF_SAMPLES - 1);
  localparam logic [3:0] SMAF_SAMPLE_MID = 4'(SMAF_SAMPLES / 2 - 1);
  localparam logic [3:0] SMAF_BITS_NINE = 4'h9;
  localparam logic [3:0] SMAF_BITS_EIGHT = 4'h8;
  localparam logic [3:0] SMAF_TX_LEN_NINE = 4'hb;
  localparam logic [3:0] SMAF_TX_LEN_EIGHT = 4'ha;
  localparam logic [1:0] SMAF_MODE_FIXED = 2'h2;
  localparam logic [1:0] SMAF_FIFO_DEPTH = 2'h2;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_PUSH} smaf_rx_e;
endpackage

/* bench/smaf_peer.sv */
// Purpose: Far-end station on the shared serial link
// Assumes: One frame at a time, bit time given in clocks
// Notes: Line idles high, as a pulled-up shared link would
`timescale 1ns/1ps
module smaf_peer (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;

  // Stop level is a choice so a broken frame can be sent on purpose
  task automatic send(input logic [7:0] d, input logic b9, input logic stp, input int bt);
    logic [10:0] f;
    f = {stp, b9, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge clk);
      rxd <= f[i];
      repeat (bt - 1) @(negedge clk);
    end
    @(negedge clk);
    rxd <= 1'b1;
  endtask

  // Samples mid-bit; ok is low when no start bit showed up
  task automatic grab(input int bt, output logic [10:0] f, output logic ok);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    ok = (n < 1000);
    repeat (bt / 2) @(negedge clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = txd;
      if (i < 10) begin
        repeat (bt) @(negedge clk);
      end
    end
  endtask
endmodule // smaf_peer

/* bench/smaf_filter_tb_top.sv */
// Purpose: Self-checking bench for the multidrop address filter
// Assumes: Mode 3 tick every other clock, so modes 1 and 3 and doubled mode 2 run 32 clocks a bit; undoubled mode 2 runs 64
// Notes: Register accesses start and end on falling edges
`timescale 1ns/1ps
module smaf_filter_tb_top import smaf_pkg::*; ;
  localparam logic [7:0] TA [5] = '{8'hf3, 8'hf0, 8'hf0, 8'hfb, 8'hf5};
  localparam logic [4:0] TN = 5'b11101;
  localparam logic [4:0] TE = 5'b11100;
  logic clk, reset, ce, sfr_wr, sfr_rd, rxd, baud_tick, txd, rx_done, tx_done, low_power_wait, power_down;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rdv;
  int n_fail = 0;
  int checks_done = 0;

  smaf_filter u_dut (.clk(clk), .reset(reset), .ce(ce), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .rxd(rxd), .baud_tick(baud_tick),
    .txd(txd), .rx_done(rx_done), .tx_done(tx_done), .low_power_wait(low_power_wait),
    .power_down(power_down));
  smaf_peer u_peer (.clk(clk), .txd(txd), .rxd(rxd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    baud_tick = 1'b0;
    forever @(negedge clk) baud_tick <= ~baud_tick;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    // Output copies trail the register by one more edge
    repeat (2) @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    rdv = sfr_rdata;
    // Let an edge pass so back-to-back reads never re-raise the strobe in one step
    @(negedge clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rdv, e);
  endtask

  // sel picks transmit done; an expected flag that never comes ends the run
  task automatic wait_done(input logic sel, input logic exp);
    int n;
    n = 0;
    @(negedge clk);
    while ((sel ? tx_done : rx_done) !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (exp && n == 200) begin
      n_fail++;
      $display("ERROR %0t done flag wait ran out", $time);
      tally_and_finish();
    end else begin
      chk({7'h00, sel ? tx_done : rx_done}, {7'h00, exp});
    end
  endtask

  initial begin
    logic [10:0] f;
    logic ok;
    reset = 1'b1;
    ce = 1'b1;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    rdc(SMAF_STATION_ADDRESS_ADDR, SMAF_REG_RESET);
    rdc(SMAF_STATION_ADDRESS_MASK_ADDR, SMAF_REG_RESET);
    rdc(SMAF_POWER_CONTROL_ADDR, 8'h00);
    rdc(SMAF_SERIAL_CONTROL_ADDR, 8'h00);
    rdc(8'h50, SMAF_UNMAPPED_READ);
    wr(SMAF_SERIAL_CONTROL_ADDR, 8'hb0);
    wr(SMAF_POWER_CONTROL_ADDR, 8'h80);
    u_peer.send(8'h37, 1'b1, 1'b1, 32);
    wait_done(1'b0, 1'b1);
    $display("test reset defaults done");
    wr(SMAF_STATION_ADDRESS_ADDR, 8'hf1);
    wr(SMAF_STATION_ADDRESS_MASK_ADDR, 8'hfa);
    rdc(SMAF_STATION_ADDRESS_ADDR, 8'hf1);
    rdc(SMAF_STATION_ADDRESS_MASK_ADDR, 8'hfa);
    for (int i = 0; i < 5; i++) begin
      wr(SMAF_SERIAL_CONTROL_ADDR, 8'hb0);
      wr(SMAF_POWER_CONTROL_ADDR, 8'h81);
      chk({7'h00, low_power_wait}, 8'h01);
      u_peer.send(TA[i], TN[i], 1'b1, 32);
      wait_done(1'b0, TE[i]);
      chk({7'h00, low_power_wait}, {7'h00, ~TE[i]});
      if (TE[i]) begin
        rdc(SMAF_SERIAL_BUFFER_ADDR, TA[i]);
        rdc(SMAF_SERIAL_CONTROL_ADDR, 8'hb5);
      end
    end
    repeat (50) @(negedge clk);
    chk({7'h00, rx_done}, 8'h01);
    $display("test address match done");
    wr(SMAF_SERIAL_CONTROL_ADDR, 8'h90);
    u_peer.send(8'h3c, 1'b0, 1'b1, 32);
    wait_done(1'b0, 1'b1);
    rdc(SMAF_SERIAL_BUFFER_ADDR, 8'h3c);
    rdc(SMAF_SERIAL_CONTROL_ADDR, 8'h91);
    u_peer.send(8'h5a, 1'b0, 1'b1, 32);
    repeat (100) @(negedge clk);
    rdc(SMAF_SERIAL_BUFFER_ADDR, 8'h3c);
    wr(SMAF_SERIAL_CONTROL_ADDR, 8'h90);
    wait_done(1'b0, 1'b1);
    rdc(SMAF_SERIAL_BUFFER_ADDR, 8'h5a);
    $display("test data and buffer done");
    wr(SMAF_SERIAL_CONTROL_ADDR, 8'h80);
    u_peer.send(8'ha5, 1'b0, 1'b1, 32);
    wait_done(1'b0, 1'b0);
    $display("test receive disabled done");
    wr(SMAF_SERIAL_CONTROL_ADDR, 8'h90);
    wr(SMAF_POWER_CONTROL_ADDR, 8'h40);
    u_peer.send(8'h11, 1'b0, 1'b0, 64);
    repeat (200) @(negedge clk);
    rd(SMAF_SERIAL_CONTROL_ADDR);
    chk({7'h00, rdv[7]}, 8'h01);
    wr(SMAF_SERIAL_CONTROL_ADDR, 8'h90);
    u_peer.send(8'h22, 1'b0, 1'b1, 64);
    wait_done(1'b0, 1'b1);
    rdc(SMAF_SERIAL_BUFFER_ADDR, 8'h22);
    rdc(SMAF_SERIAL_CONTROL_ADDR, 8'h91);
    wr(SMAF_SERIAL_CONTROL_ADDR, 8'h10);
    rdc(SMAF_SERIAL_CONTROL_ADDR, 8'h10);
    wr(SMAF_POWER_CONTROL_ADDR, 8'h00);
    rdc(SMAF_SERIAL_CONTROL_ADDR, 8'h90);
    $display("test framing error done");
    wr(SMAF_SERIAL_CONTROL_ADDR, 8'h50);
    u_peer.send(8'h6b, 1'b1, 1'b1, 32);
    wait_done(1'b0, 1'b1);
    rdc(SMAF_SERIAL_BUFFER_ADDR, 8'h6b);
    rdc(SMAF_SERIAL_CONTROL_ADDR, 8'h55);
    $display("test mode one done");
    wr(SMAF_SERIAL_CONTROL_ADDR, 8'hd0);
    u_peer.send(8'h81, 1'b1, 1'b1, 32);
    wait_done(1'b0, 1'b1);
    rdc(SMAF_SERIAL_BUFFER_ADDR, 8'h81);
    wr(SMAF_SERIAL_CONTROL_ADDR, 8'hd8);
    wr(SMAF_SERIAL_BUFFER_ADDR, 8'ha5);
    u_peer.grab(32, f, ok);
    chk({7'h00, ok}, 8'h01);
    chk(f[8:1], 8'ha5);
    chk({5'h00, f[10:9], f[0]}, 8'h06);
    wait_done(1'b1, 1'b1);
    $display("test mode three done");
    wr(SMAF_POWER_CONTROL_ADDR, 8'h02);
    chk({7'h00, power_down}, 8'h01);
    $display("test power control done");
    ce = 1'b0;
    wr(SMAF_STATION_ADDRESS_ADDR, 8'h5a);
    ce = 1'b1;
    rdc(SMAF_STATION_ADDRESS_ADDR, 8'hf1);
    $display("test clock enable done");
    tally_and_finish();
  end
endmodule // smaf_filter_tb_top
